/* File: pkg/sfc_pkg.sv */
// constants, types and register map of the serial boot flash controller
package sfc_pkg;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;

  // word offsets of the register port
  localparam logic [ADDR_W-1:0] ROM_SEG_END = 9'h100;
  localparam logic [ADDR_W-1:0] OFS_RX = 9'h100;
  localparam logic [ADDR_W-1:0] OFS_TX = 9'h101;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 9'h102;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 9'h103;
  localparam logic [ADDR_W-1:0] OFS_RSVD = 9'h104;
  localparam logic [ADDR_W-1:0] OFS_CSMASK = 9'h105;
  localparam logic [ADDR_W-1:0] OFS_EOP = 9'h106;

  // boot rom sizes
  localparam int ROM_BYTES_OLD = 512;
  localparam int ROM_BYTES_NEW = 1024;
  localparam int ROM_WORDS_OLD = ROM_BYTES_OLD / 4;
  localparam int ROM_WORDS_NEW = ROM_BYTES_NEW / 4;

  // status field positions
  localparam int STB_RX_READY = 0;
  localparam int STB_TX_READY = 1;
  localparam int STB_DONE = 2;
  localparam int STB_EOP = 3;
  localparam int STB_BUSY = 4;

  // control field positions
  localparam int CTB_IRQ_EN = 0;
  localparam int CTB_KEEP_CS = 1;

  // reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic CSMASK_RST = 1'b1;
  localparam logic [7:0] EOP_RST = 8'h00;

  // serial clock timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCLK_HALF_NS = 20;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BITS_PER_FRAME = 8;

  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sfc_req_s;

  typedef struct packed {
    logic sclk;
    logic dout;
    logic csN;
  } sfc_pin_s;

  localparam sfc_pin_s PIN_IDLE = '{sclk: 1'b0, dout: 1'b0, csN: 1'b1};

  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_LOW = 2'b01,
    SH_HIGH = 2'b10
  } sfc_shift_e;

endpackage

/* File: design/sfc_boot_flash_ctrl.sv */
// serial boot flash controller: boot rom, register port and serial shifter
////////////////////////////////////////////////////////////////////////////////
// Function
// - boot rom holds 512 bytes on older families, 1 KByte on newer ones.
// - one slave port reaches both boot rom and control registers.
// - word offsets 0x100 to 0x106 decode to six control and data registers and one reserved word.
// - word offsets 0x00 to 0xFF (0x00 to 0x7F on older families) read boot code as flat read-only memory.
// - interrupt output asserts when a serial transfer has completed.
// - dedicated-pin option drives only internal configuration pins.
// - otherwise four exported signals: data in, data out, clock, chip select.
module sfc_boot_flash_ctrl #(
  parameter bit NEWER_FAMILY = 1'b1,
  parameter bit DEDICATED_PINS = 1'b1,
  parameter logic [31:0] BOOT_IMAGE [256] = '{default: 32'h0}
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register port
  input wire sfc_pkg::sfc_req_s busReq,
  output logic [sfc_pkg::DATA_W-1:0] readData,
  output logic readValid,
  output logic irq,
  // dedicated configuration pins
  input wire logic configPinSerialIn,
  output logic configPinSerialOut,
  output logic configPinClk,
  output logic configPinChipSelectN,
  // exported flash pins
  input wire logic serialInFromFlash,
  output logic serialOutToFlash,
  output logic serialClkToFlash,
  output logic chipSelectToFlashN
);
  import sfc_pkg::*;

  localparam int ROM_WORDS = NEWER_FAMILY ? ROM_WORDS_NEW : ROM_WORDS_OLD;
  localparam int FRAME_CYC = 2 * BITS_PER_FRAME * SCLK_HALF_CYC;
  localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYC - 1);
  localparam logic [ADDR_W-1:0] ROM_LIMIT = ADDR_W'(ROM_WORDS);

  //////////////////////////////////////////////////////////////////////////////
  // state
  sfc_shift_e state_q;
  logic [7:0] txShift_q, rxShift_q, rxData_q, divCnt_q, eop_q;
  logic [2:0] bitCnt_q;
  logic [1:0] ctrl_q;
  logic csActive_q, csMask_q, rxReady_q, doneFlag_q, eopFlag_q;
  logic sync1_q, sync2_q, sync3_q, rxBit_q;
  sfc_pin_s dedPins_q, expPins_q;

  //////////////////////////////////////////////////////////////////////////////
  // address decode
  wire rd = busReq.read;
  wire wr = busReq.write;
  wire [ADDR_W-1:0] addr = busReq.addr;
  wire isRom = addr < ROM_SEG_END;
  wire romHit = addr < ROM_LIMIT;
  wire [31:0] romWord = romHit ? BOOT_IMAGE[addr[7:0]] : 32'h0;
  wire txWrite = wr && addr == OFS_TX;
  wire statusWrite = wr && addr == OFS_STATUS;
  wire ctrlWrite = wr && addr == OFS_CTRL;
  wire maskWrite = wr && addr == OFS_CSMASK;
  wire eopWrite = wr && addr == OFS_EOP;
  wire rxRead = rd && addr == OFS_RX;
  wire txReady = state_q == SH_IDLE;
  wire startXfer = txWrite && txReady;
  wire tick = divCnt_q == HALF_LAST;
  wire frameDone = state_q == SH_HIGH && tick && bitCnt_q == 3'd7;
  wire [7:0] rxNext = {rxShift_q[6:0], rxBit_q};
  wire keepCs = ctrl_q[CTB_KEEP_CS];
  wire [31:0] statusWord = {27'h0, state_q != SH_IDLE, eopFlag_q, doneFlag_q, txReady, rxReady_q};
  wire [31:0] regWord = (addr == OFS_RX) ? {24'h0, rxData_q} :
                        (addr == OFS_STATUS) ? statusWord :
                        (addr == OFS_CTRL) ? {30'h0, ctrl_q} :
                        (addr == OFS_CSMASK) ? {31'h0, csMask_q} :
                        (addr == OFS_EOP) ? {24'h0, eop_q} : 32'h0;

  // next pin levels
  sfc_pin_s pinNext;
  assign pinNext.sclk = state_q == SH_HIGH;
  assign pinNext.dout = (state_q != SH_IDLE) && txShift_q[7];
  assign pinNext.csN = !csActive_q;
  wire pinIn = DEDICATED_PINS ? configPinSerialIn : serialInFromFlash;
  wire sfc_pin_s pinNow = DEDICATED_PINS ? dedPins_q : expPins_q;

  //////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      readData <= 32'h0;
      readValid <= 1'b0;
    end
    else
    begin
      readValid <= rd;
      if (rd)
        readData <= isRom ? romWord : regWord;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctrl_q <= CTRL_RST;
      csMask_q <= CSMASK_RST;
      eop_q <= EOP_RST;
    end
    else
    begin
      if (ctrlWrite)
        ctrl_q <= busReq.wdata[1:0];
      if (maskWrite)
        csMask_q <= busReq.wdata[0];
      if (eopWrite)
        eop_q <= busReq.wdata[7:0];
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rxReady_q <= 1'b0;
      doneFlag_q <= 1'b0;
      eopFlag_q <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      rxReady_q <= frameDone || (rxReady_q && !rxRead);
      doneFlag_q <= frameDone || (doneFlag_q && !statusWrite);
      eopFlag_q <= (frameDone && rxNext == eop_q) || (eopFlag_q && !statusWrite);
      irq <= doneFlag_q && ctrl_q[CTB_IRQ_EN];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial input synchroniser
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      rxBit_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q)
        rxBit_q <= sync3_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // byte shifter, mode 0 framing
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_q <= SH_IDLE;
      txShift_q <= 8'h00;
      rxShift_q <= 8'h00;
      rxData_q <= 8'h00;
      bitCnt_q <= 3'd0;
      divCnt_q <= 8'h00;
      csActive_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        SH_IDLE:
        begin
          divCnt_q <= 8'h00;
          if (startXfer)
          begin
            txShift_q <= busReq.wdata[7:0];
            bitCnt_q <= 3'd0;
            csActive_q <= csMask_q;
            state_q <= SH_LOW;
          end
          else if (!keepCs)
            csActive_q <= 1'b0;
        end
        SH_LOW:
        begin
          divCnt_q <= tick ? 8'h00 : divCnt_q + 8'h01;
          if (tick)
            state_q <= SH_HIGH;
        end
        SH_HIGH:
        begin
          divCnt_q <= tick ? 8'h00 : divCnt_q + 8'h01;
          if (tick)
          begin
            rxShift_q <= rxNext;
            if (bitCnt_q == 3'd7)
            begin
              rxData_q <= rxNext;
              state_q <= SH_IDLE;
              if (!keepCs)
                csActive_q <= 1'b0;
            end
            else
            begin
              bitCnt_q <= bitCnt_q + 3'd1;
              txShift_q <= {txShift_q[6:0], 1'b0};
              state_q <= SH_LOW;
            end
          end
        end
        default:
          state_q <= SH_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin routing
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      dedPins_q <= PIN_IDLE;
      expPins_q <= PIN_IDLE;
    end
    else
    begin
      dedPins_q <= DEDICATED_PINS ? pinNext : PIN_IDLE;
      expPins_q <= DEDICATED_PINS ? PIN_IDLE : pinNext;
    end
  end

  assign configPinSerialOut = dedPins_q.dout;
  assign configPinClk = dedPins_q.sclk;
  assign configPinChipSelectN = dedPins_q.csN;
  assign serialOutToFlash = expPins_q.dout;
  assign serialClkToFlash = expPins_q.sclk;
  assign chipSelectToFlashN = expPins_q.csN;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_start;
    startXfer;
  endsequence
  sequence s_pinsSelected;
    !pinNow.csN ##0 pinNow.dout == $past(busReq.wdata[7], 2);
  endsequence
  property p_romSize;
    rd && addr >= ROM_LIMIT && addr < ROM_SEG_END |=> readData == 32'h0;
  endproperty
  a_romSize: assert property (p_romSize) else $error("rom read past size not zero");
  property p_onePort;
    rd |=> readValid ##1 (readValid == $past(rd));
  endproperty
  a_onePort: assert property (p_onePort) else $error("read answer missing");
  property p_statusRead;
    rd && addr == OFS_STATUS |=> readData == $past(statusWord);
  endproperty
  a_statusRead: assert property (p_statusRead) else $error("status read wrong");
  property p_romRead;
    rd && romHit |=> readData == BOOT_IMAGE[$past(addr[7:0])];
  endproperty
  a_romRead: assert property (p_romRead) else $error("boot word wrong");
  property p_irq;
    frameDone && ctrl_q[CTB_IRQ_EN] && !ctrlWrite |-> ##2 irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt after transfer");
  property p_dedicated;
    DEDICATED_PINS |-> chipSelectToFlashN && !serialClkToFlash && !serialOutToFlash;
  endproperty
  a_dedicated: assert property (p_dedicated) else $error("exported pins driven");
  property p_exported;
    !DEDICATED_PINS |-> configPinChipSelectN && !configPinClk && !configPinSerialOut;
  endproperty
  a_exported: assert property (p_exported) else $error("config pins driven");
  property p_msbFirst;
    s_start ##0 csMask_q |-> ##2 s_pinsSelected;
  endproperty
  a_msbFirst: assert property (p_msbFirst) else $error("first bit not msb");
  property p_frameLen;
    s_start |-> ##FRAME_CYC frameDone;
  endproperty
  a_frameLen: assert property (p_frameLen) else $error("frame length wrong");
endmodule

/* File: verif/sfc_flash_model.sv */
// behavioural serial flash partner
module sfc_flash_model (
  // serial link
  input wire logic csN,
  input wire logic sclk,
  input wire logic dataIn,
  output logic dataOut,
  // bench side
  input wire logic [7:0] respByte,
  output logic [7:0] gotByte,
  output int frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rxSh;
  int cnt = 0;
  ////////////////////////////////////////
  initial
  begin
    dataOut = 1'b1;
    frames = 0;
    gotByte = 8'h00;
  end
  always @(negedge csN)
  begin
    cnt = 0;
    dataOut = respByte[7];
  end
  // released line shows inverse of last bit
  always @(posedge csN) dataOut = ~dataOut;
  always @(posedge sclk)
  begin
    if (!csN)
    begin
      rxSh = {rxSh[6:0], dataIn};
      cnt++;
      if (cnt == 8)
      begin
        gotByte = rxSh;
        frames++;
        cnt = 0;
      end
    end
  end
  always @(negedge sclk) if (!csN) dataOut = respByte[7 - cnt];
endmodule

/* File: verif/testbench.sv */
// self-checking bench of the serial boot flash controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sfc_pkg::*;
  localparam bit NEW_FAM = 1'b0;
  typedef logic [31:0] sfc_img_t [256];
  function automatic logic [31:0] romWord(int i);
    return {i[7:0], ~i[7:0], i[7:0] ^ 8'h3c, 8'ha5};
  endfunction
  function automatic sfc_img_t mkImg();
    sfc_img_t img;
    for (int i = 0; i < 256; i++) img[i] = romWord(i);
    return img;
  endfunction
  function automatic logic [31:0] romExp(int i);
    return (i < (NEW_FAM ? ROM_WORDS_NEW : ROM_WORDS_OLD)) ? romWord(i) : 32'h0;
  endfunction
  function automatic logic [31:0] expSt(logic [7:0] r, logic [7:0] e);
    return {28'h0, r == e, 3'h7};
  endfunction
  localparam sfc_img_t IMG = mkImg();
  logic clkSys = 1'b0;
  logic rst = 1'b1;
  sfc_req_s req = '0;
  logic [31:0] readData;
  logic readValid, irq, pinOut, pinClk, pinCsN, pinIn, expOut, expClk, expCsN;
  logic [7:0] respByte = 8'h00;
  logic [7:0] gotByte;
  int frames;
  int numErrors = 0;
  int nCompared = 0;
  int cycles = 0;
  ////////////////////////////////////////
  sfc_boot_flash_ctrl #(.NEWER_FAMILY(NEW_FAM), .DEDICATED_PINS(1'b1), .BOOT_IMAGE(IMG))
  i_sfc_boot_flash_ctrl (
    .clk_sys(clkSys), .srst(rst), .busReq(req), .readData(readData), .readValid(readValid), .irq(irq),
    .configPinSerialIn(pinIn), .configPinSerialOut(pinOut), .configPinClk(pinClk),
    .configPinChipSelectN(pinCsN), .serialInFromFlash(1'b0), .serialOutToFlash(expOut),
    .serialClkToFlash(expClk), .chipSelectToFlashN(expCsN));
  sfc_flash_model i_sfc_flash_model (.csN(pinCsN), .sclk(pinClk), .dataIn(pinOut), .dataOut(pinIn),
    .respByte(respByte), .gotByte(gotByte), .frames(frames));
  initial forever #2.5 clkSys = ~clkSys;
  always @(posedge clkSys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      numErrors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    nCompared++;
    if (got !== exp)
    begin
      numErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(logic [8:0] a, output logic [31:0] d);
    @(negedge clkSys);
    req.read = 1'b1;
    req.addr = a;
    @(negedge clkSys);
    req.read = 1'b0;
    chk("readValid", 32'h1, {31'h0, readValid});
    d = readData;
  endtask
  task automatic rc(string n, logic [8:0] a, logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask
  task automatic wr(logic [8:0] a, logic [31:0] v);
    @(negedge clkSys);
    req.write = 1'b1;
    req.addr = a;
    req.wdata = v;
    @(negedge clkSys);
    req.write = 1'b0;
  endtask
  task automatic frame(logic [7:0] tx, logic [7:0] rsp, logic [31:0] e, logic [31:0] msk);
    logic [31:0] d;
    respByte = rsp;
    wr(OFS_TX, {24'h0, tx});
    wr(OFS_TX, {24'h0, ~tx});
    rd(OFS_STATUS, d);
    chk("busy", 32'h10, d & 32'h12);
    for (int i = 0; i < 60 && d[1] !== 1'b1; i++) rd(OFS_STATUS, d);
    chk("status", e, d & msk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    logic [7:0] tx, rsp, eop;
    logic [31:0] v;
    void'($urandom(36409));
    repeat (5) @(negedge clkSys);
    rst = 1'b0;
    rc("bootFetch", 9'h000, romExp(0));
    rc("status", OFS_STATUS, 32'h2);
    rc("control", OFS_CTRL, 32'h0);
    rc("csMask", OFS_CSMASK, 32'h1);
    rc("eop", OFS_EOP, 32'h0);
    rc("reserved", OFS_RSVD, 32'h0);
    rc("txRead", OFS_TX, 32'h0);
    rc("unmapped", 9'h107, 32'h0);
    chk("idlePins", 32'h24, {26'h0, expCsN, expClk, expOut, pinCsN, pinClk, pinOut});
    wr(9'h010, 32'hdeadbeef);
    rc("romWrite", 9'h010, romWord(16));
    rc("romEdge", 9'h07f, romExp(127));
    rc("romLast", 9'h0ff, romExp(255));
    for (int k = 0; k < 20; k++)
    begin
      v = $urandom_range(255);
      rc("rom", v[8:0], romExp(v));
    end
    for (int k = 0; k < 4; k++)
    begin
      v = $urandom;
      wr(OFS_EOP, v);
      rc("eop", OFS_EOP, v & 32'hff);
      wr(OFS_CTRL, v);
      rc("control", OFS_CTRL, v & 32'h3);
      wr(OFS_CSMASK, v);
      rc("csMask", OFS_CSMASK, v & 32'h1);
    end
    wr(OFS_CSMASK, 32'h1);
    for (int k = 0; k < 6; k++)
    begin
      tx = 8'($urandom);
      rsp = 8'($urandom);
      eop = k[0] ? rsp : 8'($urandom);
      wr(OFS_EOP, {24'h0, eop});
      wr(OFS_CTRL, {31'h0, k[1]});
      frame(tx, rsp, expSt(rsp, eop), 32'h1f);
      chk("txByte", {24'h0, tx}, {24'h0, gotByte});
      chk("frames", k + 1, frames);
      chk("csAfter", 32'h4, {29'h0, pinCsN, pinClk, expCsN ^ 1'b1});
      chk("irq", {31'h0, k[1]}, {31'h0, irq});
      rc("rxByte", OFS_RX, {24'h0, rsp});
      wr(OFS_STATUS, 32'h0);
      rc("cleared", OFS_STATUS, 32'h2);
      chk("irqLow", 32'h0, {31'h0, irq});
    end
    wr(OFS_CTRL, 32'h2);
    frame(8'h81, 8'h7e, expSt(8'h7e, eop), 32'h1f);
    chk("keepCs", 32'h0, {31'h0, pinCsN});
    wr(OFS_CTRL, 32'h0);
    repeat (2) @(negedge clkSys);
    chk("csReleased", 32'h1, {31'h0, pinCsN});
    wr(OFS_CSMASK, 32'h0);
    frame(8'h3c, 8'hc3, 32'h7, 32'h17);
    chk("maskedFrames", 32'h7, frames);
    report_and_stop();
  end
endmodule
